// file: rtl/atr_guard_consts.vh
// Constants for the answer-to-reset and guard-time block
`ifndef ATR_GUARD_CONSTS_VH
`define ATR_GUARD_CONSTS_VH
// Register byte addresses
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_FLAGS 12'h008
`define REG_GUARD_SPACING 12'h00c
`define REG_RESET_TIMING 12'h010
`define REG_GUARD_TIMES 12'h014
`define REG_CWT 12'h018
`define REG_ETU_DIV 12'h01c
`define REG_FIFO_DATA 12'h020
`define REG_FIFO_THRESH 12'h024
// Control bits
`define CTRL_ATR_START 0
`define CTRL_PROTO_T1 1
`define CTRL_TX_REQ 2
`define CTRL_USE_BGT 3
`define CTRL_LED_SEL 4
`define CTRL_SYNC_MODE 5
`define CTRL_FILTER_EN 6
// Flag bits (write one to clear)
`define FLAG_CODE_VIOL 0
`define FLAG_TX_FAIL 1
`define FLAG_CWT 2
`define FLAG_FIFO_THR 3
`define FLAG_EOM_ERR 4
`define FLAG_RESP_LATE 5
`define FLAG_TX_START 6
// Pattern and value constants
`define TS_DIRECT_BITS 10'h1b9
`define TS_INVERSE_BITS 10'h181
`define TS_DIRECT_BYTE 8'h3b
`define TS_INVERSE_BYTE 8'h3f
`define CHARS_T0 9'h102
`define CHARS_T1 9'h103
`define ETU_DEFAULT 16'h0174
`define PROC_NULL 8'h60
`define SW1_LO_A 8'h61
`define SW1_HI_A 8'h6f
`define SW1_LO_B 8'h90
`define SW1_HI_B 8'h9f
`define CHAR_BITS 4'ha
`endif

// file: rtl/sync2.v
// Two flip-flop synchroniser for a pin level
module sync2 (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Level in and out
  input wire d,
  output reg q
);
  reg meta;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: rtl/etu_timer.v
// Down counter that pulses when a loaded count of etu enables runs out
module etu_timer #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire load,
  input wire [W-1:0] count,
  input wire tick,
  input wire stop,
  // Result
  output reg running,
  output reg expired
);
  reg [W-1:0] left;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= {W{1'b0}};
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        left <= count;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (left <= {{(W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          left <= left - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// file: rtl/atr_guard_time.v
// Answer-to-reset reception, convention detect and guard-time transmit holding
//
// Register access over APB and the register offsets are this design's own decisions.
`include "atr_guard_consts.vh"
// Function
// R1 - Firmware programs default etu of 372 clocks
// R2 - Guard reloads time reset pulse, response delay
// R3 - First character starts wait timer; expiry flags
// R4 - Direct pattern selects direct, stores 0x3B
// R5 - Inverse pattern selects inverse, stores 0x3F
// R6 - Convention chosen after reset, held, reported
// R7 - Bad initial character disables receiver, flags
// R8 - Threshold above one: wait expiry sets threshold
// R9 - Unpowered card pins driven low
// R10 - Reset low until clock; I/O rises
// R11 - Cold reset released 108 to 120 etu
// R12 - Warm reset pulse 108 to 120 etu
// R13 - T=1 parity error stops FIFO, ends message
// R14 - Spacing register holds window; always active
// R15 - Counter loads 258/259, decrements per character
// R16 - Empty window reloads and stops counter
// R17 - Transmit during active counter held pending
// R18 - Underflow with pending transmit abandons, flags
// R19 - T=0 procedure bytes not counted
// R20 - Held transmit starts after window plus guard
// R21 - Firmware powers card before enabling interface
// R22 - Asynchronous mode drives activity LED itself
// R23 - Null 0x60, status 0x61-0x6F, 0x90-0x9F
// R24 - Window timed in etu, restarts each start
module atr_guard_time (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Card link
  input wire card_io_in,
  output reg card_io_out,
  output reg card_io_oe,
  output reg card_reset_n,
  output reg card_clock_out,
  // Status outputs
  output reg tx_start,
  output reg led_out
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [6:0] ctrl;
  reg [15:0] etu_div;
  reg [7:0] guard_spacing_reg;
  reg [15:0] reset_len;
  reg [15:0] resp_max;
  reg [7:0] default_guard_time;
  reg [7:0] bgt;
  reg [15:0] cwt_len;
  reg [3:0] fifo_thresh;
  reg [6:0] flags;
  reg convention_status_bit;
  reg conv_valid;
  reg rx_enabled;
  reg [8:0] received_char_counter;
  reg cpt_active;
  reg tx_pending;
  reg [7:0] last_char;
  reg [3:0] fifo_count;
  reg [7:0] card_clk_div;
  wire io_s;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire code_violation_flag = flags[`FLAG_CODE_VIOL];
  wire transmit_failure_flag = flags[`FLAG_TX_FAIL];
  sync2 u_sync (.clk(pclk), .rst_n(presetn), .d(card_io_in), .q(io_s));
  // ----------------------------------------
  // Etu and card clock dividers
  // ----------------------------------------
  reg [15:0] etu_cnt;
  reg etu_tick;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      etu_cnt <= 16'h0000;
      etu_tick <= 1'b0;
      card_clk_div <= 8'h00;
      card_clock_out <= 1'b0;
    end else begin
      etu_tick <= 1'b0;
      card_clk_div <= card_clk_div + 8'h01;
      card_clock_out <= card_clk_div[2]; // R10
      if (etu_cnt + 16'h0001 >= etu_div) begin // R1 R24
        etu_cnt <= 16'h0000;
        etu_tick <= 1'b1;
      end else begin
        etu_cnt <= etu_cnt + 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // Reset pulse and response delay (guard reloads)
  // ----------------------------------------
  wire atr_go = wr && (paddr == `REG_CTRL) && pwdata[`CTRL_ATR_START];
  wire rst_exp;
  wire rsp_exp;
  wire rst_run;
  wire rsp_run;
  reg first_seen;
  etu_timer u_rst (.clk(pclk), .rst_n(presetn), .load(atr_go), .count(reset_len), .tick(etu_tick),
    .stop(1'b0), .running(rst_run), .expired(rst_exp)); // R2 R11 R12
  etu_timer u_rsp (.clk(pclk), .rst_n(presetn), .load(rst_exp), .count(resp_max), .tick(etu_tick),
    .stop(first_seen), .running(rsp_run), .expired(rsp_exp)); // R2
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_reset_n <= 1'b0;
    end else if (atr_go) begin
      card_reset_n <= 1'b0;
    end else if (rst_exp) begin
      card_reset_n <= 1'b1;
    end
  end
  // ----------------------------------------
  // Character receiver (bit sampling at mid etu)
  // ----------------------------------------
  reg rx_busy;
  reg [3:0] bit_idx;
  reg [15:0] bit_cnt;
  reg [9:0] shreg;
  reg char_done;
  reg start_pulse;
  reg io_prev;
  wire [15:0] half_etu = {1'b0, etu_div[15:1]};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy <= 1'b0;
      bit_idx <= 4'h0;
      bit_cnt <= 16'h0000;
      shreg <= 10'h000;
      char_done <= 1'b0;
      start_pulse <= 1'b0;
      io_prev <= 1'b1;
    end else begin
      char_done <= 1'b0;
      start_pulse <= 1'b0;
      io_prev <= io_s;
      // Start only on a falling edge, so a low parity bit cannot look like a start
      if (!rx_busy) begin
        if (io_prev && !io_s && card_reset_n) begin
          rx_busy <= 1'b1;
          bit_idx <= 4'h0;
          bit_cnt <= half_etu;
          start_pulse <= 1'b1; // R24
        end
      end else if (bit_cnt == 16'h0000) begin
        bit_cnt <= etu_div - 16'h0001;
        shreg <= {shreg[8:0], io_s};
        if (bit_idx == `CHAR_BITS - 4'h1) begin
          rx_busy <= 1'b0;
          char_done <= 1'b1;
        end
        bit_idx <= bit_idx + 4'h1;
      end else begin
        bit_cnt <= bit_cnt - 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // Decode with convention
  // ----------------------------------------
  wire [7:0] raw_lsb = {shreg[1], shreg[2], shreg[3], shreg[4], shreg[5], shreg[6], shreg[7], shreg[8]};
  wire [7:0] dir_byte = raw_lsb;
  wire [7:0] inv_byte = ~shreg[8:1];
  wire [7:0] rx_byte = convention_status_bit ? inv_byte : dir_byte;
  wire par_ok = convention_status_bit ? (^shreg[8:0]) : ~(^shreg[8:0]); // R4 R5
  wire is_proc = (rx_byte == `PROC_NULL) ||
    (rx_byte >= `SW1_LO_A && rx_byte <= `SW1_HI_A) || (rx_byte >= `SW1_LO_B && rx_byte <= `SW1_HI_B); // R23
  wire count_char = char_done && !(ctrl[`CTRL_FILTER_EN] && !ctrl[`CTRL_PROTO_T1] && is_proc); // R19
  // ----------------------------------------
  // Initial character, FIFO level, wait timer
  // ----------------------------------------
  wire cwt_exp;
  etu_timer u_cwt (.clk(pclk), .rst_n(presetn), .load(char_done), .count(cwt_len), .tick(etu_tick),
    .stop(atr_go), .running(), .expired(cwt_exp)); // R3
  reg eom_stop;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      convention_status_bit <= 1'b0;
      conv_valid <= 1'b0;
      rx_enabled <= 1'b1;
      first_seen <= 1'b0;
      last_char <= 8'h00;
      fifo_count <= 4'h0;
      eom_stop <= 1'b0;
    end else if (atr_go) begin
      conv_valid <= 1'b0;
      rx_enabled <= 1'b1;
      first_seen <= 1'b0;
      eom_stop <= 1'b0;
    end else begin
      if (acc && !pwrite && paddr == `REG_FIFO_DATA && fifo_count != 4'h0)
        fifo_count <= fifo_count - 4'h1;
      if (char_done) begin
        first_seen <= 1'b1;
        if (!conv_valid) begin
          conv_valid <= 1'b1; // R6
          if (shreg == `TS_DIRECT_BITS) begin
            convention_status_bit <= 1'b0;
            last_char <= `TS_DIRECT_BYTE; // R4
            fifo_count <= fifo_count + 4'h1;
          end else if (shreg == `TS_INVERSE_BITS) begin
            convention_status_bit <= 1'b1;
            last_char <= `TS_INVERSE_BYTE; // R5
            fifo_count <= fifo_count + 4'h1;
          end else begin
            rx_enabled <= 1'b0; // R7
          end
        end else if (rx_enabled && !eom_stop) begin
          last_char <= rx_byte;
          if (fifo_count != 4'hf)
            fifo_count <= fifo_count + 4'h1;
          if (!par_ok && ctrl[`CTRL_PROTO_T1])
            eom_stop <= 1'b1; // R13
        end
      end
    end
  end
  // ----------------------------------------
  // Guard spacing window and character counter
  // ----------------------------------------
  wire win_exp;
  wire win_load = start_pulse;
  etu_timer #(.W(8)) u_win (.clk(pclk), .rst_n(presetn), .load(win_load), .count(guard_spacing_reg),
    .tick(etu_tick), .stop(1'b0), .running(), .expired(win_exp)); // R14 R24
  wire [7:0] guard_sel = ctrl[`CTRL_USE_BGT] ? bgt : default_guard_time;
  wire gt_exp;
  wire gt_run;
  etu_timer #(.W(8)) u_gt (.clk(pclk), .rst_n(presetn), .load(win_exp && tx_pending), .count(guard_sel),
    .tick(etu_tick), .stop(1'b0), .running(gt_run), .expired(gt_exp)); // R20
  wire [8:0] cpt_load = ctrl[`CTRL_PROTO_T1] ? `CHARS_T1 : `CHARS_T0;
  wire tx_req = wr && (paddr == `REG_CTRL) && pwdata[`CTRL_TX_REQ];
  wire underflow = cpt_active && count_char && received_char_counter == 9'h000;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      received_char_counter <= `CHARS_T0;
      cpt_active <= 1'b0;
      tx_pending <= 1'b0;
      tx_start <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      if (win_exp) begin
        received_char_counter <= cpt_load; // R16
        cpt_active <= 1'b0;
      end else if (count_char) begin
        if (!cpt_active) begin
          received_char_counter <= cpt_load - 9'h001; // R15
          cpt_active <= 1'b1;
        end else if (received_char_counter != 9'h000) begin
          received_char_counter <= received_char_counter - 9'h001; // R15
        end
      end
      if (underflow && tx_pending) begin
        tx_pending <= 1'b0; // R18
      end else if (tx_req) begin
        if (cpt_active || rx_busy || gt_run)
          tx_pending <= 1'b1; // R17
        else
          tx_start <= 1'b1;
      end else if (gt_exp && tx_pending) begin
        tx_pending <= 1'b0;
        tx_start <= 1'b1; // R20
      end
    end
  end
  // ----------------------------------------
  // Sticky flags, set wins over write-one clear
  // ----------------------------------------
  wire [6:0] set_v;
  assign set_v[`FLAG_CODE_VIOL] = char_done && !conv_valid && shreg != `TS_DIRECT_BITS &&
    shreg != `TS_INVERSE_BITS; // R7
  assign set_v[`FLAG_TX_FAIL] = underflow && tx_pending; // R18
  assign set_v[`FLAG_CWT] = cwt_exp; // R3
  assign set_v[`FLAG_FIFO_THR] = cwt_exp || (char_done && fifo_count + 4'h1 >= fifo_thresh); // R3 R8
  assign set_v[`FLAG_EOM_ERR] = char_done && conv_valid && rx_enabled && !eom_stop && !par_ok &&
    ctrl[`CTRL_PROTO_T1]; // R13
  assign set_v[`FLAG_RESP_LATE] = rsp_exp; // R2
  assign set_v[`FLAG_TX_START] = tx_start;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 7'h00;
    end else begin
      flags <= (flags & ~((wr && paddr == `REG_FLAGS) ? pwdata[6:0] : 7'h00)) | set_v;
    end
  end
  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 7'h00;
      etu_div <= `ETU_DEFAULT;
      guard_spacing_reg <= 8'h0c;
      reset_len <= 16'h0072;
      resp_max <= 16'h0190;
      default_guard_time <= 8'h02;
      bgt <= 8'h16;
      cwt_len <= 16'h0400;
      fifo_thresh <= 4'h1;
    end else if (wr) begin
      case (paddr)
        `REG_CTRL: ctrl <= {pwdata[6:3], 1'b0, pwdata[1], 1'b0};
        `REG_GUARD_SPACING: guard_spacing_reg <= pwdata[7:0];
        `REG_RESET_TIMING: begin
          reset_len <= pwdata[15:0];
          resp_max <= pwdata[31:16];
        end
        `REG_GUARD_TIMES: begin
          default_guard_time <= pwdata[7:0];
          bgt <= pwdata[15:8];
        end
        `REG_CWT: cwt_len <= pwdata[15:0];
        `REG_ETU_DIV: etu_div <= pwdata[15:0];
        `REG_FIFO_THRESH: fifo_thresh <= pwdata[3:0];
        default: ;
      endcase
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `REG_CTRL: prdata <= {25'h0000000, ctrl};
          `REG_STATUS: prdata <= {9'h000, tx_pending, cpt_active, received_char_counter, 4'h0, fifo_count,
            card_reset_n, rx_enabled, conv_valid, convention_status_bit};
          `REG_FLAGS: prdata <= {25'h0000000, flags};
          `REG_GUARD_SPACING: prdata <= {24'h000000, guard_spacing_reg};
          `REG_RESET_TIMING: prdata <= {resp_max, reset_len};
          `REG_GUARD_TIMES: prdata <= {16'h0000, bgt, default_guard_time};
          `REG_CWT: prdata <= {16'h0000, cwt_len};
          `REG_ETU_DIV: prdata <= {16'h0000, etu_div};
          `REG_FIFO_DATA: prdata <= {24'h000000, last_char};
          `REG_FIFO_THRESH: prdata <= {28'h0000000, fifo_thresh};
          default: pslverr <= !pwrite;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Pins and LED
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_io_out <= 1'b0;
      card_io_oe <= 1'b0;
      led_out <= 1'b0;
    end else begin
      card_io_out <= 1'b0;
      card_io_oe <= 1'b0;
      if (ctrl[`CTRL_LED_SEL] && !ctrl[`CTRL_SYNC_MODE])
        led_out <= rx_busy || cpt_active || tx_pending; // R22
      else
        led_out <= 1'b0;
    end
  end
  wire unused_ok = rsp_run ^ rst_run ^ code_violation_flag ^ transmit_failure_flag;
endmodule

// file: verif/atr_guard_time_properties.sv
// Port-level checks for the answer-to-reset and guard-time block
`include "atr_guard_consts.vh"
module atr_guard_time_properties (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Card link
  input wire card_io_in,
  input wire card_io_out,
  input wire card_io_oe,
  input wire card_reset_n,
  input wire card_clock_out,
  // Status
  input wire tx_start,
  input wire led_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles the card line has stayed idle high
  reg [7:0] idle_cnt;
  always @(posedge pclk or negedge presetn)
    if (!presetn) idle_cnt <= 8'h00;
    else if (!card_io_in) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
  property p_atr_reset_low;
    psel && penable && pwrite && paddr == `REG_CTRL && pwdata[`CTRL_ATR_START] |-> ##[1:3] !card_reset_n;
  endproperty
  a_atr_reset_low: assert property (p_atr_reset_low) else $error("card reset not lowered");
  property p_reset_pulse_min;
    $fell(card_reset_n) |=> !card_reset_n [*8];
  endproperty
  a_reset_pulse_min: assert property (p_reset_pulse_min) else $error("card reset pulse too short");
  property p_card_clk_period;
    $rose(card_clock_out) |-> ##8 $rose(card_clock_out);
  endproperty
  a_card_clk_period: assert property (p_card_clk_period) else $error("card clock period wrong");
  property p_tx_pulse;
    tx_start |=> !tx_start;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("transmit start longer than a cycle");
  property p_tx_after_idle;
    tx_start |-> idle_cnt >= 8'd32;
  endproperty
  a_tx_after_idle: assert property (p_tx_after_idle) else $error("transmit started while card busy");
  property p_tx_not_in_reset;
    tx_start |-> card_reset_n;
  endproperty
  a_tx_not_in_reset: assert property (p_tx_not_in_reset) else $error("transmit during card reset");
  property p_ready_zero_wait;
    psel && penable |-> pready;
  endproperty
  a_ready_zero_wait: assert property (p_ready_zero_wait) else $error("register access not answered");
  property p_err_only_read;
    pslverr |-> pready && !pwrite;
  endproperty
  a_err_only_read: assert property (p_err_only_read) else $error("error response out of place");
endmodule
bind atr_guard_time atr_guard_time_properties u_atr_guard_time_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .card_io_in(card_io_in), .card_io_out(card_io_out),
  .card_io_oe(card_io_oe), .card_reset_n(card_reset_n), .card_clock_out(card_clock_out),
  .tx_start(tx_start), .led_out(led_out));

// file: verif/card_model.sv
// Behavioural card: answers each reset release with an initial character and data characters
module card_model (
  // Card pins
  input wire card_clock_out,
  input wire card_reset_n,
  output reg card_io,
  // Scenario
  input wire [9:0] ts_lvl,
  input wire [9:0] data_lvl,
  input wire [9:0] n_more,
  input wire [9:0] resp
);
  timeunit 1ns;
  timeprecision 100ps;
  integer i;
  integer k;
  initial card_io = 1'b1;
  // One bit per card clock, two idle bits of guard after each character
  task send(input [9:0] lv);
    for (i = 0; i < 10; i++) begin
      card_io <= lv[i];
      @(posedge card_clock_out);
    end
    card_io <= 1'b1;
    repeat (2) @(posedge card_clock_out);
  endtask
  always @(posedge card_reset_n) begin
    repeat (resp) @(posedge card_clock_out);
    send(ts_lvl);
    for (k = 0; k < n_more; k++) send(data_lvl);
  end
endmodule

// file: verif/atr_guard_time_tb.sv
// Self-checking bench for the answer-to-reset and guard-time block
`include "atr_guard_consts.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module atr_guard_time_tb;
  timeunit 1ns;
  timeprecision 100ps;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [9:0] ts_lvl = 10'h3ff;
  reg [9:0] data_lvl = 10'h3ff;
  reg [9:0] n_more = 10'h000;
  reg [9:0] resp = 10'd40;
  reg [7:0] rnd;
  wire [31:0] prdata;
  wire pready, pslverr, card_io_out, card_io_oe, card_reset_n, card_clock_out, tx_start, led_out;
  wire card_io;
  wire card_io_in;
  int err_total = 0;
  int n_tests = 0;
  int n_tx = 0;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  // ----------------------------------------
  // Design, card and line
  // ----------------------------------------
  assign card_io_in = card_io_oe ? card_io_out : card_io;
  atr_guard_time u_atr_guard_time (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .card_io_in(card_io_in), .card_io_out(card_io_out), .card_io_oe(card_io_oe),
    .card_reset_n(card_reset_n), .card_clock_out(card_clock_out), .tx_start(tx_start), .led_out(led_out));
  card_model u_card_model (.card_clock_out(card_clock_out), .card_reset_n(card_reset_n), .card_io(card_io),
    .ts_lvl(ts_lvl), .data_lvl(data_lvl), .n_more(n_more), .resp(resp));
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (tx_start === 1'b1) n_tx++;
  // Read results are matched against the oldest expectation
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      `CHK({pslverr, prdata} & msk_q[0], exp_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  // ----------------------------------------
  // Bus and scenario tasks
  // ----------------------------------------
  task apb(input [11:0] a, input w, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input [11:0] a, input [32:0] e, input [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(a, 1'b0, 32'h0);
  endtask
  task run_atr(input [9:0] ts, input [9:0] more, input [31:0] mode, input [31:0] thr, input tx, input [9:0] r);
    int k;
    ts_lvl <= ts;
    n_more <= more;
    resp <= r;
    wr(`REG_FIFO_THRESH, thr);
    wr(`REG_CTRL, mode | 32'h1);
    repeat (4) @(posedge pclk);
    for (k = 4; k < 3000 && card_reset_n !== 1'b1; k++) @(posedge pclk);
    `CHK(k >= 108 * 8 && k <= 120 * 8, 1'b1)
    if (tx) begin
      repeat (r * 8 + 2 * 96) @(posedge pclk);
      wr(`REG_CTRL, mode | 32'h4);
      rd(`REG_STATUS, 33'h600000, 33'h600000);
      `CHK(led_out, mode[`CTRL_LED_SEL])
    end
    repeat (r * 8 + (more + 1) * 96 + 700) @(posedge pclk);
  endtask
  task report_and_stop;
    $display("Checks: %0d mismatches: %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    void'($urandom(32'hb029));
    rnd = $urandom;
    data_lvl = {^rnd, rnd, 1'b0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`REG_STATUS, 33'h0, 33'h8);
    rd(12'hffc, 33'h100000000, 33'h1ffffffff);
    `CHK({led_out, card_io_oe, card_io_out}, 3'b000)
    wr(`REG_ETU_DIV, 32'd8);
    wr(`REG_GUARD_SPACING, 32'd16);
    wr(`REG_CWT, 32'd32);
    run_atr(10'h276, 10'd0, 32'h0, 32'h1, 1'b0, 10'd40);
    rd(`REG_STATUS, 33'h102006, 33'h3ff007);
    rd(`REG_FIFO_DATA, 33'h3b, 33'hff);
    rd(`REG_FLAGS, 33'h0c, 33'h4f);
    wr(`REG_FLAGS, 32'h7f);
    run_atr(10'h206, 10'd0, 32'h2, 32'h1, 1'b0, 10'd300);
    rd(`REG_STATUS, 33'h103007, 33'h3ff007);
    rd(`REG_FIFO_DATA, 33'h3f, 33'hff);
    wr(`REG_FLAGS, 32'h7f);
    run_atr(10'h2aa, 10'd3, 32'h0, 32'h4, 1'b0, 10'd40);
    rd(`REG_STATUS, 33'h102000, 33'h3ff004);
    rd(`REG_FLAGS, 33'h0d, 33'h4f);
    wr(`REG_FLAGS, 32'h7f);
    run_atr(10'h276, 10'd4, 32'h18, 32'h1, 1'b1, 10'd40);
    rd(`REG_FLAGS, 33'h40, 33'h42);
    `CHK(n_tx, 1)
    wr(`REG_FLAGS, 32'h7f);
    run_atr(10'h276, 10'd300, 32'h0, 32'h1, 1'b1, 10'd40);
    rd(`REG_FLAGS, 33'h02, 33'h42);
    `CHK(n_tx, 1)
    wr(`REG_FLAGS, 32'h7f);
    data_lvl <= 10'h0c0;
    run_atr(10'h276, 10'd270, 32'h40, 32'h1, 1'b1, 10'd40);
    rd(`REG_FLAGS, 33'h40, 33'h42);
    `CHK(n_tx, 2)
    report_and_stop;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    report_and_stop;
  end
endmodule
